// file: shared/asc_pkg.sv
// Register map, field layout, reset values and types of the setpoint scaler
`default_nettype none
package asc_pkg;
  // Clock and lag filter timing
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned TAU_MIN_NS = 1000000; // Time constant at setting 0
  localparam int unsigned FILT_SHIFT = 4;
  localparam int unsigned FILT_TICK_CYC =
    TAU_MIN_NS / (CLK_NS * (1 << FILT_SHIFT));
  // Time constant of each setting over that of setting 0 (up to 1s)
  localparam logic [8:0][9:0] FILT_MULT = {10'h3E8, 10'h1A6, 10'h0B2,
    10'h04B, 10'h020, 10'h00D, 10'h006, 10'h002, 10'h001};
  localparam logic [3:0] FILT_MAX = 4'h8;
  localparam logic [4:0] DIV_STEPS = 5'h1C;
  // Register byte offsets
  localparam logic [7:0] OFF_RANGE = 8'h00;
  localparam logic [7:0] OFF_FILT = 8'h04;
  localparam logic [7:0] OFF_FREQ1 = 8'h08;
  localparam logic [7:0] OFF_LVL1 = 8'h0C;
  localparam logic [7:0] OFF_FREQ2 = 8'h10;
  localparam logic [7:0] OFF_LVL2 = 8'h14;
  localparam logic [7:0] OFF_DISP = 8'h18;
  localparam logic [7:0] OFF_ACCESS = 8'h1C;
  localparam logic [7:0] OFF_TERM = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_VIEW = 8'h28;
  // Field positions
  localparam int unsigned FLD_RNG2 = 4;
  localparam int unsigned FLD_HI = 16;
  localparam int unsigned FLD_PROT = 1;
  // Reset values (frequency in 0.01Hz, level in 0.1%)
  localparam logic [3:0] RNG1_RST = 4'h1;
  localparam logic [1:0] RNG2_RST = 2'h0;
  localparam logic [3:0] FILT_RST = 4'h1;
  localparam logic [15:0] GAIN_FREQ_RST = 16'h1388;
  localparam logic [15:0] BIAS_FREQ_RST = 16'h0000;
  localparam logic [15:0] BIAS1_LVL_RST = 16'h0000;
  localparam logic [15:0] BIAS2_LVL_RST = 16'h00C8;
  localparam logic [15:0] GAIN_LVL_RST = 16'h03E8;
  localparam logic [19:0] TERM_RST = 20'h00000;
  // Legal codes and limits
  localparam logic [3:0] RNG1_10V = 4'h0;
  localparam logic [3:0] RNG1_5V = 4'h1;
  localparam logic [3:0] RNG1_REV10V = 4'hA;
  localparam logic [3:0] RNG1_REV5V = 4'hB;
  localparam logic [1:0] RNG2_V5 = 2'h1;
  localparam logic [1:0] RNG2_MAX = 2'h2;
  localparam logic [15:0] FREQ_MAX = 16'h9C40;
  localparam logic [15:0] LVL_MAX = 16'h0BB8;
  localparam logic [3:0] FUNC_SECOND_EN = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Types
  typedef struct packed {
    logic rev;
    logic [15:0] mag;
  } asc_cmd_t;
  typedef struct packed {
    logic vsw;
    logic [4:0] term;
    logic [11:0] s2;
    logic [11:0] s1;
  } asc_sync_t;
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_SETUP, ST_DIV, ST_DONE}
    asc_state_t;
endpackage : asc_pkg
`default_nettype wire

// file: rtl/asc_scaler.sv
// Analog setpoint scaler with lag filter and AXI4-Lite settings
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - full-scale input of the selected range gives the gain frequency
// - second select 1 or 2 with switch at V makes it a voltage input
// - second input drives the command only while its enable is high
// - first range 10 or 11 turns on polarity-reversible operation
// - reversible 5V with bias half of gain: below 2.5V runs reverse
// - reversible current input defaults: below 4mA reverse, above forward
// - first-order lag filter, setting 0 to 8, default 1
// - filter time constant runs from about 1ms to about 1s
// - each input has a gain frequency 0 to 400Hz, default 50Hz
// - first input bias frequency 0 to 400Hz, default 0Hz
// - second input bias frequency 0 to 400Hz, default 0Hz
// - first bias level 0 to 300 percent, default 0 percent
// - gain levels 0 to 300 percent, default 100 percent
// - second bias level defaults to 20 percent, about 4mA
// - bias frequency above gain frequency gives an inverse slope
// - display unit 0 shows percent, 1 shows volts or milliamps
// - filter and scaling settings written only while visibility is 0
// - display unit stays writable whatever the write protection
// - above gain point clamp to gain, below bias point clamp to bias unless reversible
// - terminal function code 4 routes a terminal to second enable
module asc_scaler #(
  parameter int unsigned TICK_BASE = asc_pkg::FILT_TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] first_sample,
  input wire logic [11:0] second_sample,
  input wire logic [4:0] term_in,
  input wire logic volt_switch,
  output asc_pkg::asc_cmd_t freq_cmd,
  output logic second_active
);
  import asc_pkg::*;

  logic [3:0] rng1_r;
  logic [1:0] rng2_r;
  logic [3:0] filt_r;
  logic [31:0] f1_r, l1_r, f2_r, l2_r;
  logic disp_r, vis_r, prot_r;
  logic [19:0] term_r;
  asc_sync_t sy1_r, sy2_r;
  logic use2_r, en2, rev_mode;
  logic [15:0] fy1_r, fy2_r;
  logic [20:0] tcnt_r, tlim;
  logic tick_r;
  logic [11:0] pct1, pct2;
  asc_state_t st_r;
  logic [11:0] pct_r;
  logic [15:0] bl_r, gl_r, bf_r, gf_r;
  logic fix_r, neg_r;
  logic [15:0] fixv_r;
  logic [11:0] den_r;
  logic [12:0] rem_r;
  logic [27:0] quo_r;
  logic [4:0] dcnt_r;
  asc_cmd_t cmd_r;
  logic [31:0] view;

  // Input pins cross in through two flip-flops
  always_ff @(posedge aclk)
  begin
    sy1_r <= {volt_switch, term_in, second_sample, first_sample};
    sy2_r <= sy1_r;
  end

  // Second enable from any terminal mapped to function 4
  always_comb
  begin
    en2 = 1'b0;
    for (int i = 0; i < 5; i++)
      if (term_r[4*i +: 4] == FUNC_SECOND_EN && sy2_r.term[i])
        en2 = 1'b1;
  end

  assign rev_mode = rng1_r[3];
  // Full scale is 1000 (0.1%): 5V ranges halve, 10V and 20mA quarter
  assign pct1 = rng1_r[0] ? {1'b0, fy1_r[15:5]} : {2'b0, fy1_r[15:6]};
  assign pct2 = (rng2_r == RNG2_V5 && sy2_r.vsw)
    ? {1'b0, fy2_r[15:5]} : {2'b0, fy2_r[15:6]};

  // Filter tick: period scales the 1/16 step to the chosen time constant
  assign tlim = 21'(TICK_BASE) * 21'(FILT_MULT[filt_r]);
  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick_r)
      tcnt_r <= 21'h000000;
    else
      tcnt_r <= tcnt_r + 21'h000001;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_r <= 1'b0;
    else
      tick_r <= !tick_r && (tcnt_r >= tlim - 21'h000002);
  end

  // First-order lag: y += (x - y) / 16 on each tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fy1_r <= 16'h0000;
      fy2_r <= 16'h0000;
    end
    else if (tick_r)
    begin
      fy1_r <= fy1_r + 16'($signed({1'b0, sy2_r.s1, 4'h0}
        - {1'b0, fy1_r}) >>> FILT_SHIFT);
      fy2_r <= fy2_r + 16'($signed({1'b0, sy2_r.s2, 4'h0}
        - {1'b0, fy2_r}) >>> FILT_SHIFT);
    end
  end

  // Scaling sequencer: load operands, pick case, divide, publish
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= ST_IDLE;
      use2_r <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        ST_IDLE: if (tick_r) st_r <= ST_LOAD;
        ST_LOAD:
        begin
          use2_r <= en2;
          st_r <= ST_SETUP;
        end
        ST_SETUP: st_r <= fix_nxt() ? ST_DONE : ST_DIV;
        ST_DIV: if (dcnt_r == 5'h01) st_r <= ST_DONE;
        ST_DONE: st_r <= ST_IDLE;
      endcase
    end
  end

  // Whether the result is a clamp rather than an interpolation
  function automatic logic fix_nxt();
    fix_nxt = gl_r <= bl_r || 16'(pct_r) >= gl_r
      || (16'(pct_r) < bl_r && !rev_mode);
  endfunction : fix_nxt

  // Operands of the active input
  always_ff @(posedge aclk)
  begin
    if (st_r == ST_LOAD)
    begin
      pct_r <= en2 ? pct2 : pct1;
      bf_r <= en2 ? f2_r[15:0] : f1_r[15:0];
      gf_r <= en2 ? f2_r[31:16] : f1_r[31:16];
      bl_r <= en2 ? l2_r[15:0] : l1_r[15:0];
      gl_r <= en2 ? l2_r[31:16] : l1_r[31:16];
    end
  end

  // Case selection and restoring divider for the interpolation
  always_ff @(posedge aclk)
  begin
    logic [11:0] d;
    logic [15:0] dm;
    logic [12:0] t;
    d = 12'h000;
    dm = 16'h0000;
    t = 13'h0000;
    if (st_r == ST_SETUP)
    begin
      d = 16'(pct_r) < bl_r ? 12'(bl_r - 16'(pct_r)) : 12'(16'(pct_r) - bl_r);
      dm = gf_r < bf_r ? bf_r - gf_r : gf_r - bf_r;
      fix_r <= fix_nxt();
      fixv_r <= (16'(pct_r) >= gl_r) ? gf_r : bf_r;
      neg_r <= (gf_r < bf_r) ^ (16'(pct_r) < bl_r);
      den_r <= 12'(gl_r - bl_r);
      quo_r <= 28'(dm * d);
      rem_r <= 13'h0000;
      dcnt_r <= DIV_STEPS;
    end
    else if (st_r == ST_DIV)
    begin
      t = {rem_r[11:0], quo_r[27]};
      if (t >= {1'b0, den_r})
        rem_r <= t - {1'b0, den_r};
      else
        rem_r <= t;
      quo_r <= {quo_r[26:0], t >= {1'b0, den_r}};
      dcnt_r <= dcnt_r - 5'h01;
    end
  end

  // Command: signed sum gives direction, magnitude clipped to 400Hz
  always_ff @(posedge aclk)
  begin
    logic signed [29:0] res;
    res = 30'sh0;
    if (!aresetn)
      cmd_r <= '0;
    else if (st_r == ST_DONE)
    begin
      if (fix_r)
        res = $signed({14'h0000, fixv_r});
      else if (neg_r)
        res = $signed({14'h0000, bf_r}) - $signed({2'h0, quo_r});
      else
        res = $signed({14'h0000, bf_r}) + $signed({2'h0, quo_r});
      cmd_r.rev <= res < 0;
      if (res < 0)
        res = -res;
      cmd_r.mag <= res > $signed({14'h0000, FREQ_MAX})
        ? FREQ_MAX : res[15:0];
    end
  end

  // Levels of the active input in percent, or with display unit 1 in volts or milliamps (0.01 units)
  always_comb
  begin
    logic [15:0] b, g;
    b = use2_r ? l2_r[15:0] : l1_r[15:0];
    g = use2_r ? l2_r[31:16] : l1_r[31:16];
    view = {g, b};
    if (disp_r)
    begin
      if (use2_r && !(rng2_r != 2'h0 && sy2_r.vsw))
        view = {g[14:0], 1'b0, b[14:0], 1'b0};
      else if (use2_r ? rng2_r == RNG2_V5 : rng1_r[0])
        view = {1'b0, g[15:1], 1'b0, b[15:1]};
    end
  end

  // Register read view
  function automatic logic [31:0] reg_val(input logic [7:0] a);
    unique case (a)
      OFF_RANGE: reg_val = 32'({rng2_r, rng1_r});
      OFF_FILT: reg_val = 32'(filt_r);
      OFF_FREQ1: reg_val = f1_r;
      OFF_LVL1: reg_val = l1_r;
      OFF_FREQ2: reg_val = f2_r;
      OFF_LVL2: reg_val = l2_r;
      OFF_DISP: reg_val = 32'(disp_r);
      OFF_ACCESS: reg_val = 32'({prot_r, vis_r});
      OFF_TERM: reg_val = 32'(term_r);
      OFF_STATUS: reg_val = 32'({rev_mode, use2_r, cmd_r});
      OFF_VIEW: reg_val = view;
      default: reg_val = 32'h00000000;
    endcase
  endfunction : reg_val

  // Write channel: address and data may arrive in either order
  logic [7:0] wa_r;
  logic [31:0] wd_r, wv, wm;
  logic [3:0] ws_r;
  logic wr_go;
  logic [1:0] wresp;
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wm = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
  // Strobed bytes merged with the current value; a process, so that a
  // register change read inside the function is seen as well
  always_comb
  begin
    wv = (reg_val(wa_r) & ~wm) | (wd_r & wm);
  end

  // Decode, lock and range check of a write
  always_comb
  begin
    logic lk, ok;
    lk = prot_r;
    ok = 1'b1;
    unique case (wa_r)
      OFF_RANGE: ok = wv[5:4] <= RNG2_MAX && (wv[3:0] == RNG1_10V
        || wv[3:0] == RNG1_5V || wv[3:0] == RNG1_REV10V
        || wv[3:0] == RNG1_REV5V);
      OFF_FILT:
      begin
        lk = prot_r || vis_r;
        ok = wv[3:0] <= FILT_MAX;
      end
      OFF_FREQ1, OFF_FREQ2:
      begin
        lk = prot_r || vis_r;
        ok = wv[15:0] <= FREQ_MAX && wv[31:16] <= FREQ_MAX;
      end
      OFF_LVL1, OFF_LVL2:
      begin
        lk = prot_r || vis_r;
        ok = wv[15:0] <= LVL_MAX && wv[31:16] <= LVL_MAX;
      end
      OFF_DISP, OFF_ACCESS: lk = 1'b0;
      OFF_TERM: ok = 1'b1;
      OFF_STATUS, OFF_VIEW: ok = 1'b0;
      default: ok = 1'b0;
    endcase
    if (wa_r > OFF_VIEW || wa_r[1:0] != 2'h0)
      wresp = RESP_DECERR;
    else
      wresp = (lk || !ok) ? RESP_SLVERR : RESP_OKAY;
  end

  // Write handshake and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        wa_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wresp;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Settings registers, updated only by accepted writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rng1_r <= RNG1_RST;
      rng2_r <= RNG2_RST;
      filt_r <= FILT_RST;
      f1_r <= {GAIN_FREQ_RST, BIAS_FREQ_RST};
      l1_r <= {GAIN_LVL_RST, BIAS1_LVL_RST};
      f2_r <= {GAIN_FREQ_RST, BIAS_FREQ_RST};
      l2_r <= {GAIN_LVL_RST, BIAS2_LVL_RST};
      disp_r <= 1'b0;
      vis_r <= 1'b0;
      prot_r <= 1'b0;
      term_r <= TERM_RST;
    end
    else if (wr_go && wresp == RESP_OKAY)
    begin
      unique case (wa_r)
        OFF_RANGE: {rng2_r, rng1_r} <= wv[FLD_RNG2 + 1:0];
        OFF_FILT: filt_r <= wv[3:0];
        OFF_FREQ1: f1_r <= wv;
        OFF_LVL1: l1_r <= wv;
        OFF_FREQ2: f2_r <= wv;
        OFF_LVL2: l2_r <= wv;
        OFF_DISP: disp_r <= wv[0];
        OFF_ACCESS: {prot_r, vis_r} <= wv[FLD_PROT:0];
        OFF_TERM: term_r <= wv[19:0];
        default: disp_r <= disp_r;
      endcase
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= reg_val(s_axi_araddr);
      s_axi_rresp <= (s_axi_araddr > OFF_VIEW || s_axi_araddr[1:0] != 2'h0)
        ? RESP_DECERR : RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  assign freq_cmd = cmd_r;
  assign second_active = use2_r;

  // Checks on the settings and the scaling path
  a_filt_default: assert property (@(posedge aclk)
    $rose(aresetn) |-> filt_r == FILT_RST && l2_r[15:0] == BIAS2_LVL_RST)
    else $error("filter or second bias level not at reset value");
  a_lock_scale: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && vis_r |=> $stable(filt_r) && $stable(f1_r) && $stable(l2_r))
    else $error("scaling setting changed while locked");
  a_disp_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wa_r == OFF_DISP && ws_r[0] |=> disp_r == $past(wd_r[0])
      && s_axi_bresp == RESP_OKAY)
    else $error("display unit write refused");
  a_clamp_gain: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_SETUP && gl_r > bl_r && 16'(pct_r) >= gl_r
      |=> ##1 cmd_r.mag == gf_r && !cmd_r.rev)
    else $error("command not clamped to gain frequency");
  a_clamp_bias: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_SETUP && !rev_mode && gl_r > bl_r && 16'(pct_r) < bl_r
      |=> ##1 cmd_r.mag == bf_r)
    else $error("command not clamped to bias frequency");
  a_rev_below: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_SETUP && rev_mode && bf_r == 16'h0000 && gl_r > bl_r
      && gf_r > 16'h0000 && 16'(pct_r) < bl_r
      |-> ##[2:31] st_r == ST_IDLE && cmd_r.rev)
    else $error("no reverse below the bias point");
  a_div_time: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_SETUP ##1 st_r == ST_DIV |-> ##27 st_r == ST_DIV ##1
      st_r == ST_DONE)
    else $error("interpolation did not finish in 28 steps");
  a_sel_second: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_LOAD |=> use2_r == $past(en2)
      && gf_r == ($past(en2) ? $past(f2_r[31:16]) : $past(f1_r[31:16])))
    else $error("wrong input chosen for the command");
endmodule : asc_scaler
`default_nettype wire

// file: verif/asc_source.sv
// Model of the external analog setpoint sources feeding the scaler
`timescale 1ns/100ps
`default_nettype none
module asc_source (
  input wire logic aclk,
  input wire logic [11:0] first_target,
  input wire logic [11:0] second_target,
  input wire logic current_mode,
  input wire logic [11:0] slew,
  output logic [11:0] first_sample,
  output logic [11:0] second_sample,
  output logic volt_switch
);
  // Switch position matches the kind of signal the source delivers
  assign volt_switch = ~current_mode;

  // Moves one level toward its target, at once or by slew per cycle
  function automatic logic [11:0] step_to(input logic [11:0] cur,
                                          input logic [11:0] tgt);
    logic [11:0] gap;
    gap = (tgt > cur) ? tgt - cur : cur - tgt;
    if (slew == 12'h000 || gap <= slew)
      return tgt;
    return (tgt > cur) ? cur + slew : cur - slew;
  endfunction : step_to

  // Both sources follow their targets from the first clock edge on
  always @(posedge aclk)
  begin
    first_sample <= step_to(first_sample, first_target);
    second_sample <= step_to(second_sample, second_target);
  end
endmodule : asc_source
`default_nettype wire

// file: verif/asc_scaler_test.sv
// Self-checking testbench of the analog setpoint scaler
`timescale 1ns/100ps
`default_nettype none
module asc_scaler_test;
  import asc_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, arvalid, cur_mode, vs;
  logic awready, wready, bvalid, arready, rvalid, second_active;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [11:0] s1_t, s2_t, slew, s1, s2;
  logic [4:0] term;
  asc_cmd_t freq_cmd;
  int fail_count, checks;

  asc_scaler #(.TICK_BASE(4)) asc_scaler_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .first_sample(s1),
    .second_sample(s2), .term_in(term), .volt_switch(vs),
    .freq_cmd(freq_cmd), .second_active(second_active));
  asc_source asc_source_i (.aclk(aclk), .first_target(s1_t),
    .second_target(s2_t), .current_mode(cur_mode), .slew(slew),
    .first_sample(s1), .second_sample(s2), .volt_switch(vs));

  // Clock of 50 ns
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Counts a comparison and reports a mismatch
  task chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  task expect_mag(input logic [15:0] e, input string m);
    chk(freq_cmd.mag === e, m);
  endtask : expect_mag

  // One write; ready lines are sampled at the rising edge
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!got && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        got = 1'b1;
        chk(bresp === e, "write response");
      end
    end
    chk(got, "write not answered");
  endtask : wr

  // One read, compared with the expected word and response
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!got && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        got = 1'b1;
        chk(rdata === e && rresp === er, "read data");
      end
    end
    chk(got, "read not answered");
  endtask : rd

  // Sets both source levels and lets the filter settle
  task apply(input logic [11:0] a, input logic [11:0] b);
    s1_t <= a;
    s2_t <= b;
    repeat (800) @(posedge aclk);
  endtask : apply

  task t_reset;
    chk(freq_cmd === 17'h00000 && second_active === 1'b0, "reset outputs");
    rd(OFF_RANGE, 32'h00000001, RESP_OKAY);
    rd(OFF_FILT, 32'h00000001, RESP_OKAY);
    rd(OFF_FREQ1, 32'h13880000, RESP_OKAY);
    rd(OFF_LVL1, 32'h03E80000, RESP_OKAY);
    rd(OFF_FREQ2, 32'h13880000, RESP_OKAY);
    rd(OFF_LVL2, 32'h03E800C8, RESP_OKAY);
    rd(OFF_DISP, 32'h00000000, RESP_OKAY);
    rd(8'h40, 32'h00000000, RESP_DECERR);
  endtask : t_reset

  task t_protect;
    wr(OFF_FILT, 32'h00000009, RESP_SLVERR);
    wr(OFF_ACCESS, 32'h00000001, RESP_OKAY);
    wr(OFF_FILT, 32'h00000000, RESP_SLVERR);
    wr(OFF_ACCESS, 32'h00000002, RESP_OKAY);
    wr(OFF_DISP, 32'h00000001, RESP_OKAY);
    rd(OFF_DISP, 32'h00000001, RESP_OKAY);
    wr(OFF_RANGE, 32'h00000000, RESP_SLVERR);
    wr(OFF_ACCESS, 32'h00000000, RESP_OKAY);
    wr(OFF_DISP, 32'h00000000, RESP_OKAY);
    wr(8'h3C, 32'h00000000, RESP_DECERR);
    wr(OFF_FILT, 32'h00000000, RESP_OKAY);
    rd(OFF_FILT, 32'h00000000, RESP_OKAY);
  endtask : t_protect

  task t_scale;
    slew <= 12'h010;
    apply(12'h834, 12'h000);
    expect_mag(16'h1388, "5V full scale");
    slew <= 12'h000;
    wr(OFF_RANGE, 32'h00000000, RESP_OKAY);
    apply(12'hFFF, 12'h000);
    expect_mag(16'h1388, "10V full scale");
    apply(12'h834, 12'h000);
    chk(freq_cmd.mag >= 16'h0A20 && freq_cmd.mag <= 16'h0A45, "10V");
    wr(OFF_FREQ1, 32'h0FA00000, RESP_OKAY);
    apply(12'h7D0, 12'h000);
    chk(freq_cmd.mag >= 16'h07BC && freq_cmd.mag <= 16'h07DA, "mid");
  endtask : t_scale

  task t_clamp;
    wr(OFF_LVL1, 32'h03E80064, RESP_OKAY);
    wr(OFF_FREQ1, 32'h0FA003E8, RESP_OKAY);
    apply(12'h000, 12'h000);
    expect_mag(16'h03E8, "below bias");
    apply(12'hFFF, 12'h000);
    expect_mag(16'h0FA0, "above gain");
    wr(OFF_FREQ1, 32'h03E81770, RESP_OKAY);
    apply(12'h000, 12'h000);
    expect_mag(16'h1770, "inverse low");
    apply(12'hFFF, 12'h000);
    expect_mag(16'h03E8, "inverse high");
  endtask : t_clamp

  task t_second;
    wr(OFF_LVL1, 32'h03E80000, RESP_OKAY);
    wr(OFF_FREQ1, 32'h13880000, RESP_OKAY);
    wr(OFF_TERM, 32'h00000004, RESP_OKAY);
    wr(OFF_FREQ2, 32'h0BB80000, RESP_OKAY);
    term <= 5'h01;
    apply(12'hFFF, 12'hFFF);
    chk(second_active === 1'b1 && freq_cmd.mag === 16'h0BB8, "on");
    rd(OFF_STATUS, 32'h00020BB8, RESP_OKAY);
    term <= 5'h00;
    apply(12'hFFF, 12'hFFF);
    chk(second_active === 1'b0 && freq_cmd.mag === 16'h1388, "off");
    wr(OFF_RANGE, 32'h00000010, RESP_OKAY);
    cur_mode <= 1'b0;
    term <= 5'h01;
    apply(12'hFFF, 12'h834);
    expect_mag(16'h0BB8, "second 5V");
    rd(OFF_VIEW, 32'h03E800C8, RESP_OKAY);
    wr(OFF_DISP, 32'h00000001, RESP_OKAY);
    rd(OFF_VIEW, 32'h01F40064, RESP_OKAY);
    wr(OFF_DISP, 32'h00000000, RESP_OKAY);
  endtask : t_second

  task t_reverse;
    term <= 5'h00;
    cur_mode <= 1'b1;
    wr(OFF_RANGE, 32'h0000000B, RESP_OKAY);
    wr(OFF_LVL1, 32'h03E801F4, RESP_OKAY);
    apply(12'h064, 12'h000);
    chk(freq_cmd.rev === 1'b1 && freq_cmd.mag !== 16'h0000, "rev");
    apply(12'h76C, 12'h000);
    chk(freq_cmd.rev === 1'b0, "forward");
    wr(OFF_RANGE, 32'h0000000A, RESP_OKAY);
    term <= 5'h01;
    apply(12'h000, 12'h190);
    chk(freq_cmd.rev === 1'b1, "current reverse");
    apply(12'h000, 12'h960);
    chk(freq_cmd.rev === 1'b0, "current forward");
  endtask : t_reverse

  task t_filter;
    term <= 5'h00;
    wr(OFF_RANGE, 32'h00000001, RESP_OKAY);
    wr(OFF_LVL1, 32'h03E80000, RESP_OKAY);
    apply(12'h000, 12'h000);
    wr(OFF_FILT, 32'h00000008, RESP_OKAY);
    s1_t <= 12'h834;
    repeat (400) @(posedge aclk);
    chk(freq_cmd.mag < 16'h03E8, "slow filter");
    wr(OFF_FILT, 32'h00000000, RESP_OKAY);
    repeat (4000) @(posedge aclk);
    apply(12'h834, 12'h000);
    expect_mag(16'h1388, "fast filter");
  endtask : t_filter

  task conclude;
    $display("Mismatches %0d, comparisons %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // Main sequence
  initial
  begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    s1_t = 12'h000;
    s2_t = 12'h000;
    slew = 12'h000;
    cur_mode = 1'b1;
    term = 5'h00;
    fail_count = 0;
    checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_protect;
    t_scale;
    t_clamp;
    t_second;
    t_reverse;
    t_filter;
    conclude;
  end

  // Watchdog against a hang
  initial
  begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude;
  end
endmodule : asc_scaler_test
`default_nettype wire
